// >>> hdl/uor_ep.sv
/*
 OUT endpoint receive path: packet acceptance, nak control, counters,
 completion entries, interrupts and an AXI4-Lite register slave.
 Assumes the link layer gives one-cycle packet events and token strobes
 synchronous to aclk; the payload bytes themselves are stored elsewhere.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module uor_ep (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pkt_valid,
   input wire uor_pkg::uor_pkt_t pkt,
   input wire logic token_valid,
   output logic token_nak,
   output logic token_ack,
   input wire logic [13:0] received_frame_number,
   output logic irq
);
   import uor_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [10:0] mps_reg;
   logic iso_reg;
   logic odd_reg;
   logic nak_reg;
   logic ena_reg;
   logic [18:0] size_reg;
   logic [9:0] cnt_reg;
   logic [1:0] rxpid_reg;
   logic [1:0] last_pid_reg;
   logic pid_valid_reg;
   logic done_pend_reg;
   logic [2:0] sts_reg;
   logic [2:0] en_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;

   // ----------------------------------------------------------------
   // fifo
   // ----------------------------------------------------------------
   uor_entry_t f_wdata;
   uor_entry_t f_rdata;
   logic f_wr;
   logic f_rd;
   logic f_empty;
   logic f_full;
   logic [4:0] f_count;
   // status entries only; payload bytes live in a separate buffer
   uor_fifo u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(f_wr),
      .wr_data(f_wdata),
      .rd_en(f_rd),
      .rd_data(f_rdata),
      .empty(f_empty),
      .full(f_full),
      .count(f_count)
   );

   // ----------------------------------------------------------------
   // packet acceptance
   // ----------------------------------------------------------------
   wire frame_ok = !iso_reg || (odd_reg == received_frame_number[0]);
   wire ep_open = ena_reg && !nak_reg && frame_ok;
   wire dup_pkt = !pkt.iso && pid_valid_reg && (pkt.pid == last_pid_reg);
   wire pkt_take = pkt_valid && ep_open && pkt.crc_ok
      && !dup_pkt && !f_full;
   wire pkt_drop_full = pkt_valid && ep_open && pkt.crc_ok && f_full;
   wire pkt_short = pkt.len < mps_reg;
   wire [9:0] cnt_after = cnt_reg - 10'h001;
   // done entry waits one free slot after the packet goes in
   wire done_push = done_pend_reg && !pkt_take && !f_full;
   assign f_wr = pkt_take || done_push;
   assign f_wdata = pkt_take
      ? uor_entry_t'{kind: KIND_PACKET, pid: pkt.pid, len: pkt.len}
      : uor_entry_t'{kind: KIND_DONE, pid: PID_DATA0, len: 11'h000};

   // ----------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------
   wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   wire [7:0] ra = s_axi_araddr[7:0];
   wire ra_hit = (s_axi_araddr[31:8] == 24'h000000) && (ra[1:0] == 2'h0)
      && (ra <= OFS_FRAME);
   wire wa_hit = (aw_addr_reg <= OFS_FRAME);
   wire wr_ctl = wr_fire && (aw_addr_reg == OFS_CONTROL) && w_strb_reg[3];
   wire wr_xs = wr_fire && (aw_addr_reg == OFS_XFER_SIZE) && (&w_strb_reg);
   wire wr_clr = wr_fire && (aw_addr_reg == OFS_IRQ_CLEAR) && w_strb_reg[0];
   wire wr_en_r = wr_fire && (aw_addr_reg == OFS_IRQ_ENABLE) && w_strb_reg[0];
   // a read of the pop register takes the head entry
   assign f_rd = rd_fire && (ra == OFS_FIFO_POP) && !f_empty;
   wire pop_pkt = f_rd && (f_rdata.kind == KIND_PACKET);
   wire pop_done = f_rd && (f_rdata.kind == KIND_DONE);
   // nak strobes at bits 26 and 27 are write-one and read back as zero
   wire [31:0] ctl_word = {ena_reg, 12'h000, nak_reg, odd_reg, iso_reg,
      5'h00, mps_reg};
   wire [31:0] xs_word = {1'b0, rxpid_reg, cnt_reg, size_reg};
   wire [31:0] pop_word = {15'h0000, f_empty, 1'b0, f_rdata};
   wire [31:0] rd_word =
      (ra == OFS_CONTROL) ? ctl_word :
      (ra == OFS_XFER_SIZE) ? xs_word :
      (ra == OFS_IRQ_STATUS) ? {29'h0, sts_reg} :
      (ra == OFS_IRQ_ENABLE) ? {29'h0, en_reg} :
      (ra == OFS_FIFO_POP) ? pop_word :
      (ra == OFS_FIFO_STAT) ? {27'h0, f_count} :
      (ra == OFS_FRAME) ? {18'h0, received_frame_number} :
      AXI_DECERR_DATA;

   // ----------------------------------------------------------------
   // interrupt events
   // ----------------------------------------------------------------
   // an event in the same cycle as its clear leaves the bit set
   wire [2:0] ev = {pkt_drop_full, pkt_take, pop_done};
   wire [2:0] clr = wr_clr ? w_data_reg[2:0] : 3'h0;
   wire [2:0] sts_next = ev | (sts_reg & ~clr);

   // ----------------------------------------------------------------
   // endpoint control state
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mps_reg <= 11'h000;
         iso_reg <= 1'b0;
         odd_reg <= 1'b0;
         nak_reg <= 1'b1;
         ena_reg <= 1'b0;
      end else begin
         if (wr_ctl) begin
            mps_reg <= w_data_reg[CTL_MPS_LSB +: 11];
            iso_reg <= w_data_reg[CTL_ISO_BIT];
            odd_reg <= w_data_reg[CTL_ODD_BIT];
            ena_reg <= w_data_reg[CTL_ENA_BIT];
         end
         if (pop_done) begin
            ena_reg <= 1'b0;
         end
         // set-nak and the automatic nak both win over clear-nak
         if (wr_ctl && w_data_reg[CTL_CLEAR_NAK_BIT_BIT]) begin
            nak_reg <= 1'b0;
         end
         if (wr_ctl && w_data_reg[CTL_SNAK_BIT]) begin
            nak_reg <= 1'b1;
         end
         if (pkt_take && (cnt_after == 10'h000 || pkt_short)) begin
            nak_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         size_reg <= 19'h00000;
         cnt_reg <= 10'h000;
         rxpid_reg <= PID_DATA0;
      end else begin
         // a size register write wins over a pop in the same cycle
         if (wr_xs) begin
            size_reg <= w_data_reg[XS_SIZE_LSB +: 19];
         end else if (pop_pkt) begin
            size_reg <= uor_sub_len(size_reg, f_rdata.len);
         end
         if (wr_xs) begin
            cnt_reg <= w_data_reg[XS_CNT_LSB +: 10];
         end else if (pkt_take) begin
            cnt_reg <= cnt_after;
         end
         if (pop_pkt && iso_reg) begin
            rxpid_reg <= f_rdata.pid;
         end
      end
   end

   // ----------------------------------------------------------------
   // duplicate tracking and completion
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_pid_reg <= PID_DATA0;
         pid_valid_reg <= 1'b0;
         done_pend_reg <= 1'b0;
      end else begin
         // a fresh enable forgets the last pid, so no first-packet repeat
         if (wr_ctl && w_data_reg[CTL_ENA_BIT]) begin
            pid_valid_reg <= 1'b0;
         end
         if (pkt_take && !pkt.iso) begin
            last_pid_reg <= pkt.pid;
            pid_valid_reg <= 1'b1;
         end
         if (pkt_take && (cnt_after == 10'h000 || pkt_short)) begin
            done_pend_reg <= 1'b1;
         end else if (done_push) begin
            done_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // token handshake and interrupts
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         token_nak <= 1'b0;
         token_ack <= 1'b0;
         sts_reg <= IRQ_RESET;
         en_reg <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         // answers stand for one cycle, one cycle after the token strobe
         token_nak <= token_valid && !iso_reg
            && (!ep_open || f_full);
         token_ack <= token_valid && !iso_reg && ep_open && !f_full;
         sts_reg <= sts_next;
         if (wr_en_r) begin
            en_reg <= w_data_reg[2:0];
         end
         irq <= |(sts_next & (wr_en_r ? w_data_reg[2:0] : en_reg));
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite handshakes
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_got_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= (s_axi_awaddr[31:8] == 24'h000000
               && s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[7:0] : 8'hFF;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= ra_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : uor_ep
`default_nettype wire

// >>> hdl/uor_fifo.sv
/*
 Receive FIFO of status entries for the OUT endpoint.
 Assumes writer checks full and reader checks empty before acting.
*/
`timescale 1ns/100ps
`default_nettype none
module uor_fifo (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire uor_pkg::uor_entry_t wr_data,
   input wire logic rd_en,
   output uor_pkg::uor_entry_t rd_data,
   output logic empty,
   output logic full,
   output logic [4:0] count
);
   import uor_pkg::*;
   uor_entry_t mem [FIFO_DEPTH];
   logic [3:0] wp_reg;
   logic [3:0] rp_reg;
   logic [4:0] cnt_reg;
   wire do_wr = wr_en && !full;
   wire do_rd = rd_en && !empty;
   assign empty = (cnt_reg == FIFO_CNT_ZERO);
   assign full = (cnt_reg == 5'(FIFO_DEPTH));
   assign count = cnt_reg;
   assign rd_data = mem[rp_reg];
   always_ff @(posedge aclk) begin
      if (do_wr) begin
         mem[wp_reg] <= wr_data;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_reg <= 4'h0;
         rp_reg <= 4'h0;
         cnt_reg <= FIFO_CNT_ZERO;
      end else begin
         wp_reg <= wp_reg + 4'(do_wr);
         rp_reg <= rp_reg + 4'(do_rd);
         cnt_reg <= cnt_reg + 5'(do_wr) - 5'(do_rd);
      end
   end
endmodule : uor_fifo
`default_nettype wire

// >>> hdl/uor_pkg.sv
/*
 OUT endpoint receive package: register offsets, field positions, reset
 values, packet-event and FIFO-entry structs, and a helper function.
 Assumes one clock (aclk, 100 MHz) and an AXI4-Lite register bus.
*/
package uor_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_XFER_SIZE = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] OFS_FIFO_POP = 8'h14;
   localparam logic [7:0] OFS_FIFO_STAT = 8'h18;
   localparam logic [7:0] OFS_FRAME = 8'h1C;
   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTL_MPS_LSB = 0;
   localparam int CTL_ISO_BIT = 16;
   localparam int CTL_ODD_BIT = 17;
   localparam int CTL_NAK_BIT = 18;
   localparam int CTL_CLEAR_NAK_BIT_BIT = 26;
   localparam int CTL_SNAK_BIT = 27;
   localparam int CTL_ENA_BIT = 31;
   // ----------------------------------------------------------------
   // transfer size register fields
   // ----------------------------------------------------------------
   localparam int XS_SIZE_LSB = 0;
   localparam int XS_CNT_LSB = 19;
   localparam int XS_PID_LSB = 29;
   // ----------------------------------------------------------------
   // interrupt status bits
   // ----------------------------------------------------------------
   localparam int IRQ_TRANSFER_COMPLETE_IRQ = 0;
   localparam int IRQ_RXNE = 1;
   localparam int IRQ_DROP = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   // ----------------------------------------------------------------
   // fifo geometry and codes
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_CNT_ZERO = 5'h00;
   localparam logic [1:0] PID_DATA0 = 2'h0;
   localparam logic [1:0] KIND_PACKET = 2'h0;
   localparam logic [1:0] KIND_DONE = 2'h1;
   localparam logic [31:0] AXI_DECERR_DATA = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one received OUT data packet reported by the link layer
   typedef struct packed {
      logic [10:0] len;
      logic [1:0] pid;
      logic crc_ok;
      logic iso;
   } uor_pkt_t;

   // one receive fifo status entry
   typedef struct packed {
      logic [1:0] kind;
      logic [1:0] pid;
      logic [10:0] len;
   } uor_entry_t;

   function automatic logic [18:0] uor_sub_len(input logic [18:0] size,
                                               input logic [10:0] len);
      if (size > {8'h00, len}) begin
         return size - {8'h00, len};
      end
      return 19'h00000;
   endfunction : uor_sub_len
endpackage : uor_pkg

// >>> sim/uor_ep_assertions.sv
/*
 Checker for uor_ep register-bus and token answer timing.
 Assumes it is bound to uor_ep and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module uor_ep_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic token_valid,
   input wire logic token_nak,
   input wire logic token_ack
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_hs;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ar_hs;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_tok_excl;
      !(token_nak && token_ack);
   endproperty
   property p_tok_cause;
      (token_nak || token_ack) |-> $past(token_valid);
   endproperty
   property p_b_after_wr;
      s_wr_hs |-> ##[2:3] s_axi_bvalid;
   endproperty
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_aw_pulse;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_r_after_ar;
      s_ar_hs |=> s_axi_rvalid;
   endproperty
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   property p_ar_pulse;
      s_ar_hs |=> !s_axi_arready;
   endproperty
   a_tok_excl: assert property (p_tok_excl)
      else $error("token nak and ack together");
   a_tok_cause: assert property (p_tok_cause)
      else $error("token answer without token");
   a_b_after_wr: assert property (p_b_after_wr)
      else $error("write response late");
   a_b_once: assert property (p_b_once)
      else $error("write response repeated");
   a_aw_pulse: assert property (p_aw_pulse)
      else $error("awready held after handshake");
   a_r_after_ar: assert property (p_r_after_ar)
      else $error("read data late");
   a_r_once: assert property (p_r_once)
      else $error("read data repeated");
   a_ar_pulse: assert property (p_ar_pulse)
      else $error("arready held after handshake");
endmodule : uor_ep_chk
bind uor_ep uor_ep_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .token_valid(token_valid), .token_nak(token_nak),
   .token_ack(token_ack));
`default_nettype wire

// >>> sim/uor_host.sv
/*
 Link-side model of the USB host: OUT data packets and OUT tokens.
 Assumes the endpoint samples one-cycle strobes at the rising aclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module uor_host (
   input wire logic aclk,
   output logic pkt_valid,
   output uor_pkg::uor_pkt_t pkt,
   output logic token_valid,
   input wire logic token_nak,
   input wire logic token_ack
);
   import uor_pkg::*;
   initial begin
      pkt_valid = 1'b0;
      pkt = '0;
      token_valid = 1'b0;
   end
   // fields are scrambled once the strobe drops; resends are the caller's
   task automatic send(input logic [10:0] len, input logic [1:0] pid,
                       input logic crc_ok, input logic iso);
      @(posedge aclk);
      pkt_valid <= 1'b1;
      pkt <= uor_pkt_t'({len, pid, crc_ok, iso});
      @(posedge aclk);
      pkt_valid <= 1'b0;
      pkt <= uor_pkt_t'(~pkt);
   endtask : send
   task automatic token(output logic nak, output logic ack);
      @(posedge aclk);
      token_valid <= 1'b1;
      @(posedge aclk);
      token_valid <= 1'b0;
      @(posedge aclk);
      nak = token_nak;
      ack = token_ack;
   endtask : token
endmodule : uor_host
`default_nettype wire

// >>> sim/usb_device_out_endpoint_receive_tb.sv
/*
 Bench for uor_ep: AXI4-Lite tasks and packet sequences with expectations.
 Assumes uor_host drives the link side and the checker is bound.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module usb_device_out_endpoint_receive_tb;
   import uor_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic [13:0] frame = '0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic pkt_valid, tok_v, nak, ack, tn, ta;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   uor_pkt_t pkt;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 aclk = ~aclk;
   uor_ep u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .pkt_valid(pkt_valid), .pkt(pkt),
      .token_valid(tok_v), .token_nak(nak), .token_ack(ack),
      .received_frame_number(frame), .irq(irq));
   uor_host u_host (.aclk(aclk), .pkt_valid(pkt_valid), .pkt(pkt),
      .token_valid(tok_v), .token_nak(nak), .token_ack(ack));
   // ----
   // bus tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
   endtask : rd
   task automatic arm(input int s, input int c, input logic iso, odd);
      wr(OFS_XFER_SIZE, (32'(c) << XS_CNT_LSB) | 32'(s));
      wr(OFS_CONTROL, (32'h1 << CTL_ENA_BIT) | (32'h1 << CTL_CLEAR_NAK_BIT_BIT)
         | (32'(odd) << CTL_ODD_BIT) | (32'(iso) << CTL_ISO_BIT) | 32'h40);
   endtask : arm
   task automatic pop(input logic [1:0] k, p, input logic [10:0] l);
      rd(OFS_FIFO_POP);
      `CHK(d[16:13], {2'b00, k})
      if (k == KIND_PACKET) begin
         `CHK(d[12:0], {p, l})
      end
   endtask : pop
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches++;
         conclude();
      end
   end
   // ----
   // scenarios
   // ----
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CONTROL);
      `CHK({d[CTL_ENA_BIT], d[CTL_NAK_BIT]}, 2'b01)
      `CHK(r, RESP_OKAY)
      wr(OFS_IRQ_ENABLE, 32'h7);
      `CHK(r, RESP_OKAY)
      arm(128, 2, 1'b0, 1'b0);
      u_host.token(tn, ta);
      `CHK({tn, ta}, 2'b01)
      u_host.send(11'd64, 2'd0, 1'b1, 1'b0);
      rd(OFS_IRQ_STATUS);
      `CHK(d[IRQ_RXNE], 1'b1)
      `CHK(irq, 1'b1)
      u_host.send(11'd64, 2'd1, 1'b0, 1'b0);
      u_host.send(11'd64, 2'd0, 1'b1, 1'b0);
      rd(OFS_FIFO_STAT);
      `CHK(d[4:0], 5'h01)
      rd(OFS_XFER_SIZE);
      `CHK(d[28:0], {10'd1, 19'd128})
      u_host.send(11'd64, 2'd1, 1'b1, 1'b0);
      u_host.send(11'd64, 2'd0, 1'b1, 1'b0);
      rd(OFS_CONTROL);
      `CHK(d[CTL_NAK_BIT], 1'b1)
      u_host.token(tn, ta);
      `CHK({tn, ta}, 2'b10)
      rd(OFS_FIFO_STAT);
      `CHK(d[4:0], 5'h03)
      pop(KIND_PACKET, 2'd0, 11'd64);
      rd(OFS_XFER_SIZE);
      `CHK(d[18:0], 19'd64)
      pop(KIND_PACKET, 2'd1, 11'd64);
      pop(KIND_DONE, 2'd0, 11'd0);
      rd(OFS_IRQ_STATUS);
      `CHK(d[IRQ_TRANSFER_COMPLETE_IRQ], 1'b1)
      rd(OFS_CONTROL);
      `CHK(d[CTL_ENA_BIT], 1'b0)
      rd(OFS_FIFO_POP);
      `CHK(d[16], 1'b1)
      arm(128, 2, 1'b0, 1'b0);
      u_host.send(11'd10, 2'd0, 1'b1, 1'b0);
      rd(OFS_FIFO_STAT);
      `CHK(d[4:0], 5'h02)
      pop(KIND_PACKET, 2'd0, 11'd10);
      pop(KIND_DONE, 2'd0, 11'd0);
      rd(OFS_XFER_SIZE);
      `CHK(d[28:0], {10'd1, 19'd118})
      for (int o = 0; o < 2; o++) begin
         arm(64, 1, 1'b1, o[0]);
         frame <= {13'h0, ~o[0]};
         u_host.send(11'd64, 2'(2 - o), 1'b1, 1'b1);
         u_host.token(tn, ta);
         `CHK({tn, ta}, 2'b00)
         rd(OFS_FIFO_STAT);
         `CHK(d[4:0], 5'h00)
         frame <= {13'h15, o[0]};
         u_host.send(11'd64, 2'(2 - o), 1'b1, 1'b1);
         rd(OFS_FIFO_STAT);
         `CHK(d[4:0], 5'h02)
         pop(KIND_PACKET, 2'(2 - o), 11'd64);
         rd(OFS_XFER_SIZE);
         `CHK(d[30:29], 2'(2 - o))
         `CHK(d[28:19], 10'd0)
         pop(KIND_DONE, 2'd0, 11'd0);
      end
      arm(1280, 20, 1'b0, 1'b0);
      for (int i = 0; i < 17; i++) begin
         u_host.send(11'd64, 2'(i % 2), 1'b1, 1'b0);
      end
      rd(OFS_FIFO_STAT);
      `CHK(d[4:0], 5'h10)
      rd(OFS_XFER_SIZE);
      `CHK(d[28:19], 10'd4)
      rd(OFS_IRQ_STATUS);
      `CHK(d[IRQ_DROP], 1'b1)
      u_host.token(tn, ta);
      `CHK({tn, ta}, 2'b10)
      for (int i = 0; i < 16; i++) begin
         pop(KIND_PACKET, 2'(i % 2), 11'd64);
      end
      rd(OFS_XFER_SIZE);
      `CHK(d[18:0], 19'd256)
      wr(OFS_IRQ_CLEAR, 32'h7);
      wr(OFS_IRQ_ENABLE, 32'h0);
      u_host.send(11'd64, 2'd0, 1'b1, 1'b0);
      rd(OFS_IRQ_STATUS);
      `CHK({irq, d[2:0]}, 4'h2)
      wr(OFS_IRQ_ENABLE, 32'h2);
      rd(OFS_IRQ_STATUS);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLEAR, 32'h2);
      rd(OFS_IRQ_STATUS);
      `CHK({irq, d[2:0]}, 4'h0)
      wr(OFS_CONTROL, (32'h1 << CTL_ENA_BIT) | (32'h1 << CTL_SNAK_BIT)
         | 32'h40);
      u_host.token(tn, ta);
      `CHK({tn, ta}, 2'b10)
      rd(8'h40);
      `CHK({r, d}, {RESP_SLVERR, AXI_DECERR_DATA})
      wr(8'h40, 32'h5A5A_A5A5);
      `CHK(r, RESP_SLVERR)
      conclude();
   end
endmodule : usb_device_out_endpoint_receive_tb
`default_nettype wire
